// file: sra_pkg.sv
// Constants, types and helpers shared by both ends of the serial register port
//
// Overview of operation
// [R1] Select held low frames access; high ignored
// [R2] Device samples data in on clock rise
// [R3] No minimum serial clock rate assumed
// [R4] Single access is one 24-bit frame
// [R5] All fields shifted most significant first
// [R6] Wide registers little-endian, low byte first
// [R7] Data out floats except read data bits
// [R8] First bit one reads, zero writes
// [R9] Next 15 bits carry register address
// [R10] Write frame stores final eight bits
// [R11] Read frame drives register on final eight
// [R12] Held select streams further data bytes
// [R13] Streaming steps address once per byte
// [R14] Direction bit picks increment or decrement
// [R15] Freeze bit stops address advance
// [R16] Host avoids access during calibration
// [R17] Gain trims change only by writes
// [R18] Separate offset trim per core 0-5
// [R19] Absent input trims stored, no effect
// [R20] Full-scale setting common to all inputs
// [R21] No offset trim writes during offset calibration
// [R22] Deselect clears counter, drops partial write
`default_nettype none
package sra_pkg;
  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int         ADDR_W      = 15;
  localparam int         HDR_BITS    = 16;
  localparam logic [4:0] HDR_LAST    = 5'h0F;
  localparam logic [4:0] DATA_FIRST  = 5'h10;
  localparam logic [4:0] FRAME_LAST  = 5'h17;
  localparam int         NUM_CORES   = 6;
  localparam int         NUM_INPUTS  = 4;
  localparam int         REG_DEPTH   = 64;
  // ----------------------------------------------------------------
  // Device register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [14:0] ADDR_USR_CFG  = 15'h0000;
  localparam int          CFG_DEC_BIT   = 0;
  localparam int          CFG_HOLD_BIT  = 1;
  localparam logic [7:0]  USR_CFG_RST   = 8'h00;
  localparam logic [14:0] ADDR_FS       = 15'h0002;
  localparam logic [15:0] FS_RST        = 16'hA000;
  localparam logic [14:0] ADDR_BANDGAP  = 15'h0004;
  localparam logic [14:0] ADDR_TERM     = 15'h0005;
  localparam logic [14:0] ADDR_OFS      = 15'h0010;
  localparam logic [14:0] ADDR_GAIN     = 15'h0020;
  localparam logic [7:0]  TRIM_RST      = 8'h00;
  // ----------------------------------------------------------------
  // Host APB registers
  // ----------------------------------------------------------------
  localparam logic [11:0] HOST_CTRL     = 12'h000;
  localparam logic [11:0] HOST_WDATA    = 12'h004;
  localparam logic [11:0] HOST_RDATA    = 12'h008;
  localparam logic [11:0] HOST_STATUS   = 12'h00C;
  localparam int          CTRL_RD_BIT   = 15;
  localparam int          CTRL_LEN_LSB  = 16;
  localparam int          CTRL_GO_BIT   = 31;
  localparam int          STAT_BUSY_BIT = 0;
  localparam int          STAT_DONE_BIT = 1;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         CLK_PERIOD_NS  = 25;
  localparam int         SCLK_PERIOD_NS = 400;
  localparam logic [4:0] SCLK_HALF_CYC  = 5'(SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS));
  // ----------------------------------------------------------------
  // Variants and helpers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {VAR_QUAD, VAR_DUAL, VAR_SINGLE} sra_variant_t;

  // Cores fitted on each variant
  function automatic logic [5:0] sra_core_mask(input sra_variant_t v);
    case (v)
      VAR_DUAL:   sra_core_mask = 6'h07;
      VAR_SINGLE: sra_core_mask = 6'h05;
      default:    sra_core_mask = 6'h3F;
    endcase
  endfunction

  // Inputs fitted on each variant
  function automatic logic [3:0] sra_input_mask(input sra_variant_t v);
    case (v)
      VAR_DUAL:   sra_input_mask = 4'h3;
      VAR_SINGLE: sra_input_mask = 4'h1;
      default:    sra_input_mask = 4'hF;
    endcase
  endfunction

  // Streaming address step
  function automatic logic [14:0] sra_addr_step(input logic [14:0] a, input logic dec, input logic hold);
    if (hold) begin
      sra_addr_step = a;
    end else if (dec) begin
      sra_addr_step = a - 15'h0001;
    end else begin
      sra_addr_step = a + 15'h0001;
    end
  endfunction
endpackage
`default_nettype wire

// file: sra_if.sv
// Serial link wires joining the host end and the device end
`timescale 1ns/10ps
`default_nettype none
interface sra_if;
  logic sclk;
  logic serial_select_n;
  logic serial_data_in;
  logic serial_data_out;
  logic serial_data_out_oe_n;
  logic serial_data_out_line;

  // Floating data out reads as high, like a weak pull-up
  assign serial_data_out_line = serial_data_out_oe_n ? 1'b1 : serial_data_out;

  modport device (
    input  sclk,
    input  serial_select_n,
    input  serial_data_in,
    output serial_data_out,
    output serial_data_out_oe_n
  );
  modport host (
    output sclk,
    output serial_select_n,
    output serial_data_in,
    input  serial_data_out_line
  );
endinterface
`default_nettype wire

// file: sra_sync.sv
// Two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module sra_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // sra_sync
`default_nettype wire

// file: sra_device.sv
// Device end: serial register port and trim register file
`timescale 1ns/10ps
`default_nettype none
module sra_device
  import sra_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic          ce,
  sra_if.device              link,
  input  wire sra_variant_t  variant,
  input  wire logic          offset_cal_enable,
  input  wire logic          cal_ofs_we,
  input  wire logic [2:0]    cal_ofs_core,
  input  wire logic [15:0]   cal_ofs_value,
  output logic      [15:0]   full_scale_setting,
  output logic      [7:0]    bandgap_trim,
  output logic      [31:0]   termination_trim,
  output logic      [95:0]   core_offset_trim,
  output logic      [95:0]   core_gain_trim,
  output logic               stream_addr_direction
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic              sel_n_s;
  logic              sclk_s;
  logic              sdi_s;
  logic              sclk_prev_q;
  logic [4:0]        cnt_q;
  logic              rd_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0]        wsh_q;
  logic [7:0]        rsh_q;
  logic              sdo_q;
  logic              sdo_oe_n_q;
  logic [7:0]        regs_q [REG_DEPTH];
  logic              active;
  logic              rise;
  logic              fall;
  logic              hdr_done;
  logic              byte_done;
  logic              in_data;
  logic [ADDR_W-1:0] hdr_addr;
  logic [ADDR_W-1:0] next_addr;
  logic [7:0]        wbyte;
  logic [5:0]        cmask;
  logic [3:0]        imask;
  logic [5:0]        cal_idx;

  // Reads outside the register file return zero
  function automatic logic [7:0] rd_byte(input logic [ADDR_W-1:0] a);
    if (a < 15'(REG_DEPTH)) begin
      rd_byte = regs_q[a[5:0]];
    end else begin
      rd_byte = 8'h00;
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  // Pins are asynchronous to clk, so all three pass two stages
  sra_sync #(.W(3)) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .ce   (ce),
    .d    ({link.serial_select_n, link.sclk, link.serial_data_in}),
    .q    ({sel_n_s, sclk_s, sdi_s})
  );

  // Edge detection on the synchronised serial clock
  assign active    = ~sel_n_s;                      // [R1]
  assign rise      = active & sclk_s & ~sclk_prev_q; // [R2]
  assign fall      = active & ~sclk_s & sclk_prev_q;
  assign hdr_done  = rise & (cnt_q == HDR_LAST);
  assign byte_done = rise & (cnt_q == FRAME_LAST);   // [R4]
  assign in_data   = (cnt_q >= DATA_FIRST);
  assign hdr_addr  = {addr_q[ADDR_W-2:0], sdi_s};    // [R5]
  assign wbyte     = {wsh_q[6:0], sdi_s};            // [R5]
  assign next_addr = sra_addr_step(addr_q,
                                   regs_q[ADDR_USR_CFG[5:0]][CFG_DEC_BIT],
                                   regs_q[ADDR_USR_CFG[5:0]][CFG_HOLD_BIT]); // [R13] [R14] [R15]
  assign cmask     = sra_core_mask(variant);
  assign imask     = sra_input_mask(variant);
  assign cal_idx   = ADDR_OFS[5:0] + {2'b00, cal_ofs_core, 1'b0};

  // ----------------------------------------------------------------
  // Bit counter
  // ----------------------------------------------------------------
  // Only edges count, never clk cycles, so any slow or halted clock works
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclk_prev_q <= 1'b0;
      cnt_q       <= 5'h00;
    end else if (ce) begin
      sclk_prev_q <= sclk_s;
      if (!active) begin
        cnt_q <= 5'h00;                              // [R22] [R1]
      end else if (byte_done) begin
        cnt_q <= DATA_FIRST;                         // [R12]
      end else if (rise) begin
        cnt_q <= cnt_q + 5'h01;                      // [R3]
      end
    end
  end

  // ----------------------------------------------------------------
  // Header and write shifting
  // ----------------------------------------------------------------
  // Direction bit first, then address, then data byte
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_q   <= 1'b0;
      addr_q <= '0;
      wsh_q  <= 8'h00;
    end else if (ce) begin
      if (rise && cnt_q == 5'h00) begin
        rd_q <= sdi_s;                               // [R8]
      end
      if (rise && cnt_q != 5'h00 && !in_data) begin
        addr_q <= hdr_addr;                          // [R9]
      end else if (byte_done) begin
        addr_q <= next_addr;                         // [R13]
      end
      if (rise && in_data) begin
        wsh_q <= wbyte;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Only a full byte is committed; a byte cut short leaves its register intact
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < REG_DEPTH; i++) begin
        regs_q[i] <= TRIM_RST;
      end
      regs_q[ADDR_USR_CFG[5:0]]         <= USR_CFG_RST;
      regs_q[ADDR_FS[5:0]]              <= FS_RST[7:0];
      regs_q[ADDR_FS[5:0] + 6'h01]      <= FS_RST[15:8];
    end else if (ce) begin
      if (byte_done && !rd_q && addr_q < 15'(REG_DEPTH)) begin
        regs_q[addr_q[5:0]] <= wbyte;                // [R10] [R22]
      end
      // Calibration reaches offset trims only; gain trims have no such path
      if (offset_cal_enable && cal_ofs_we && cal_ofs_core < 3'(NUM_CORES)) begin
        regs_q[cal_idx]         <= cal_ofs_value[7:0];  // [R21] [R6] [R17]
        regs_q[cal_idx + 6'h01] <= cal_ofs_value[15:8]; // [R6]
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data output
  // ----------------------------------------------------------------
  // New bit goes out after a falling edge so the host can sample on the rise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rsh_q      <= 8'h00;
      sdo_q      <= 1'b0;
      sdo_oe_n_q <= 1'b1;
    end else if (ce) begin
      if (!active) begin
        sdo_q      <= 1'b0;
        sdo_oe_n_q <= 1'b1;                          // [R7]
      end else if (hdr_done) begin
        rsh_q <= rd_byte(hdr_addr);                  // [R11]
      end else if (byte_done) begin
        rsh_q <= rd_byte(next_addr);                 // [R12]
      end else if (fall && rd_q && in_data) begin
        sdo_q      <= rsh_q[7];                      // [R11] [R5]
        rsh_q      <= {rsh_q[6:0], 1'b0};
        sdo_oe_n_q <= 1'b0;                          // [R7]
      end
    end
  end

  assign link.serial_data_out      = sdo_q;
  assign link.serial_data_out_oe_n = sdo_oe_n_q;

  // ----------------------------------------------------------------
  // Trim outputs
  // ----------------------------------------------------------------
  // Absent cores and inputs keep their bytes but drive zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      full_scale_setting    <= FS_RST;
      bandgap_trim          <= TRIM_RST;
      termination_trim      <= '0;
      core_offset_trim      <= '0;
      core_gain_trim        <= '0;
      stream_addr_direction <= 1'b0;
    end else if (ce) begin
      full_scale_setting    <= {regs_q[ADDR_FS[5:0] + 6'h01], regs_q[ADDR_FS[5:0]]}; // [R20] [R6]
      bandgap_trim          <= regs_q[ADDR_BANDGAP[5:0]];
      stream_addr_direction <= regs_q[ADDR_USR_CFG[5:0]][CFG_DEC_BIT];               // [R14]
      for (int i = 0; i < NUM_INPUTS; i++) begin
        termination_trim[i*8 +: 8] <= imask[i] ? regs_q[ADDR_TERM[5:0] + 6'(i)] : 8'h00; // [R19]
      end
      for (int i = 0; i < NUM_CORES; i++) begin
        core_offset_trim[i*16 +: 16] <= cmask[i] ?
          {regs_q[ADDR_OFS[5:0] + 6'(2*i+1)], regs_q[ADDR_OFS[5:0] + 6'(2*i)]} : 16'h0000;   // [R18] [R19]
        core_gain_trim[i*16 +: 16]   <= cmask[i] ?
          {regs_q[ADDR_GAIN[5:0] + 6'(2*i+1)], regs_q[ADDR_GAIN[5:0] + 6'(2*i)]} : 16'h0000; // [R17] [R19]
      end
    end
  end
endmodule // sra_device
`default_nettype wire

// file: sra_host.sv
// Host end: APB-programmed serial master for the register port
`timescale 1ns/10ps
`default_nettype none
module sra_host
  import sra_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  sra_if.host              link
);
  typedef enum {H_IDLE, H_LOW, H_HIGH, H_HOLD, H_GAP} sra_hstate_t;

  sra_hstate_t state_q;
  logic [4:0]  div_q;
  logic [5:0]  bit_q;
  logic [5:0]  total_q;
  logic [47:0] tx_q;
  logic [7:0]  rsh_q;
  logic [31:0] ctrl_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic        busy_q;
  logic        done_q;
  logic        sclk_q;
  logic        ss_n_q;
  logic        sdi_q;
  logic        sdo_s;
  logic        acc;
  logic        go;
  logic        div_end;
  logic [5:0]  dbit;

  assign acc     = psel & penable & pready;
  assign go      = acc & pwrite & (paddr == HOST_CTRL) & pwdata[CTRL_GO_BIT] & ~busy_q;
  assign div_end = (div_q == SCLK_HALF_CYC - 5'h01);
  assign dbit    = bit_q - 6'(HDR_BITS);

  // Read data line crosses in from the device domain
  sra_sync #(.W(1)) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .ce   (ce),
    .d    (link.serial_data_out_line),
    .q    (sdo_s)
  );

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // One wait state so that pready and prdata come from flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
      ctrl_q  <= '0;
      wdata_q <= '0;
    end else if (ce) begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & (paddr > HOST_STATUS);
      if (psel && penable && !pready && !pwrite) begin
        if (paddr == HOST_CTRL) begin
          prdata <= ctrl_q;
        end else if (paddr == HOST_WDATA) begin
          prdata <= wdata_q;
        end else if (paddr == HOST_RDATA) begin
          prdata <= rdata_q;
        end else if (paddr == HOST_STATUS) begin
          prdata <= {30'h0, done_q, busy_q};
        end else begin
          prdata <= '0;
        end
      end
      if (go) begin
        ctrl_q <= pwdata;
      end
      if (acc && pwrite && paddr == HOST_WDATA && !busy_q) begin
        wdata_q <= pwdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial sequencer
  // ----------------------------------------------------------------
  // Clock divided from clk; select stays low across all bytes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= H_IDLE;
      div_q   <= 5'h00;
      bit_q   <= 6'h00;
      total_q <= 6'h00;
      tx_q    <= '0;
      sclk_q  <= 1'b0;
      ss_n_q  <= 1'b1;
      sdi_q   <= 1'b0;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
    end else if (ce) begin
      div_q <= div_end ? 5'h00 : div_q + 5'h01;
      case (state_q)
        H_IDLE: begin
          div_q <= 5'h00;
          if (go) begin
            tx_q    <= {pwdata[CTRL_RD_BIT], pwdata[14:0], wdata_q[7:0], wdata_q[15:8],
                        wdata_q[23:16], wdata_q[31:24]};      // [R8] [R9] [R6] [R5]
            sdi_q   <= pwdata[CTRL_RD_BIT];
            total_q <= 6'(HDR_BITS) + {1'b0, pwdata[CTRL_LEN_LSB +: 2], 3'b111} + 6'h01; // [R4] [R12]
            bit_q   <= 6'h00;
            ss_n_q  <= 1'b0;                                  // [R1]
            busy_q  <= 1'b1;
            done_q  <= 1'b0;
            state_q <= H_LOW;
          end
        end
        H_LOW: begin
          if (div_end) begin
            sclk_q  <= 1'b1;
            bit_q   <= bit_q + 6'h01;
            state_q <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (div_end) begin
            sclk_q <= 1'b0;
            if (bit_q == total_q) begin
              state_q <= H_HOLD;
            end else begin
              tx_q    <= {tx_q[46:0], 1'b0};
              sdi_q   <= tx_q[46];                            // [R5]
              state_q <= H_LOW;
            end
          end
        end
        H_HOLD: begin
          if (div_end) begin
            ss_n_q  <= 1'b1;                                  // [R1] [R22]
            state_q <= H_GAP;
          end
        end
        H_GAP: begin
          // Select stays high long enough for the device to see it
          if (div_end) begin
            busy_q  <= 1'b0;
            done_q  <= 1'b1;
            state_q <= H_IDLE;
          end
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read capture
  // ----------------------------------------------------------------
  // Sampled just before the rise, after the device changed it on the fall
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rsh_q   <= 8'h00;
      rdata_q <= '0;
    end else if (ce) begin
      if (state_q == H_LOW && div_end && bit_q >= 6'(HDR_BITS)) begin
        rsh_q <= {rsh_q[6:0], sdo_s};                         // [R11]
        if (dbit[2:0] == 3'h7) begin
          rdata_q[dbit[4:3]*8 +: 8] <= {rsh_q[6:0], sdo_s};   // [R6]
        end
      end
    end
  end

  assign link.sclk            = sclk_q;
  assign link.serial_select_n = ss_n_q;
  assign link.serial_data_in  = sdi_q;
endmodule // sra_host
`default_nettype wire

// file: sra_link_sva.sv
// Link protocol checker for the serial register port
`timescale 1ns/10ps
`default_nettype none
module sra_link_sva (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic serial_select_n,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe_n
);
  logic [7:0] rises_q;
  logic       sclk_q;
  logic       dir_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Raw clock rises per frame; cleared while deselected so each frame counts afresh
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclk_q  <= 1'b0;
      rises_q <= 8'h00;
    end else begin
      sclk_q  <= sclk;
      rises_q <= serial_select_n ? 8'h00 : rises_q + 8'((sclk && !sclk_q) ? 1 : 0);
    end
  end
  // Direction bit seen at the first rise of a frame
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dir_q <= 1'b0;
    end else if (!serial_select_n && sclk && !sclk_q && rises_q == 8'h00) begin
      dir_q <= serial_data_in;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_hi8;
    sclk [*8];
  endsequence
  sequence s_idle8;
    serial_select_n [*8];
  endsequence
  property p_sclk_half; $rose(sclk) |-> s_hi8 ##1 !sclk; endproperty
  property p_idle_low; serial_select_n |-> !sclk; endproperty
  property p_frame_len; $rose(serial_select_n) |-> rises_q >= 8'h18 && rises_q[2:0] == 3'h0; endproperty
  property p_sdi_hold; $rose(sclk) |-> $stable(serial_data_in); endproperty
  property p_hdr_float; $fell(serial_data_out_oe_n) |-> dir_q && rises_q >= 8'h10 && !serial_select_n; endproperty
  property p_release; $rose(serial_select_n) |-> ##[0:6] serial_data_out_oe_n; endproperty
  property p_sdo_steady; !serial_data_out_oe_n && sclk |-> $stable(serial_data_out); endproperty
  property p_float_idle; s_idle8 |-> serial_data_out_oe_n; endproperty
  a_sclk_half: assert property (p_sclk_half) else $error("clock high phase wrong");
  a_idle_low: assert property (p_idle_low) else $error("clock moves while deselected");
  a_frame_len: assert property (p_frame_len) else $error("frame not whole bytes");
  a_sdi_hold: assert property (p_sdi_hold) else $error("data in changed at rise");
  a_hdr_float: assert property (p_hdr_float) else $error("data out driven early");
  a_release: assert property (p_release) else $error("data out not released");
  a_sdo_steady: assert property (p_sdo_steady) else $error("read bit moved while high");
  a_float_idle: assert property (p_float_idle) else $error("data out driven idle");
endmodule // sra_link_sva
`default_nettype wire

// file: tb_top.sv
// Testbench joining host and device ends over the serial link
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import sra_pkg::*;
;
  logic         clk = 1'b0;
  logic         nrst = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0;
  sra_variant_t variant = VAR_QUAD;
  logic         ocal_en = 1'b0;
  logic         ocal_we = 1'b0;
  logic [2:0]   ocal_core = 3'h0;
  logic [15:0]  ocal_val = 16'h0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [15:0]  fs;
  logic [7:0]   bg;
  logic [31:0]  term;
  logic [95:0]  ofs;
  logic [95:0]  gain;
  logic         sdir;
  logic [31:0]  rd;
  logic         apb_err;
  int           miscompares = 0;
  int           n_checks = 0;
  int           cyc = 0;
  sra_if link_if ();
  sra_host sra_host_i (.clk(clk), .nrst(nrst), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_if));
  sra_device sra_device_i (.clk(clk), .nrst(nrst), .ce(1'b1), .link(link_if), .variant(variant),
    .offset_cal_enable(ocal_en), .cal_ofs_we(ocal_we), .cal_ofs_core(ocal_core), .cal_ofs_value(ocal_val),
    .full_scale_setting(fs), .bandgap_trim(bg), .termination_trim(term), .core_offset_trim(ofs),
    .core_gain_trim(gain), .stream_addr_direction(sdir));
  sra_link_sva sra_link_sva_i (.clk(clk), .nrst(nrst), .sclk(link_if.sclk),
    .serial_select_n(link_if.serial_select_n), .serial_data_in(link_if.serial_data_in),
    .serial_data_out(link_if.serial_data_out), .serial_data_out_oe_n(link_if.serial_data_out_oe_n));
  // 40 MHz clock
  always #12.5 clk = ~clk;
  // Hang guard: about three and a half times the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic finish_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer; waits on pready, the hang guard bounds it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd      = prdata;
    apb_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Whole serial access: data, go, poll busy, fetch read bytes
  task automatic xfer(input logic r, input logic [14:0] a, input logic [1:0] lm1, input logic [31:0] d);
    apb(1'b1, HOST_WDATA, d);
    apb(1'b1, HOST_CTRL, {1'b1, 13'h0000, lm1, r, a});
    rd = 32'h1;
    while (rd[STAT_BUSY_BIT] !== 1'b0) apb(1'b0, HOST_STATUS, 32'h0);
    apb(1'b0, HOST_RDATA, 32'h0);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk("fs reset", 32'(fs), 32'h0000A000);
    xfer(1'b1, 15'h0002, 2'h1, 32'h0);
    chk("fs read", {16'h0000, rd[15:0]}, 32'h0000A000);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", {apb_err, rd[30:0]}, 32'h80000000);
    $display("test reset done");
  endtask
  task automatic t_stream;
    xfer(1'b0, 15'h0002, 2'h2, 32'h0077C321);
    chk("fs", 32'(fs), 32'h0000C321);
    chk("bandgap", 32'(bg), 32'h00000077);
    xfer(1'b1, 15'h0002, 2'h2, 32'h0);
    chk("stream read", {8'h00, rd[23:0]}, 32'h0077C321);
    $display("test stream done");
  endtask
  task automatic t_dir;
    xfer(1'b0, 15'h0000, 2'h0, 32'h1);
    chk("direction", 32'(sdir), 32'h1);
    xfer(1'b0, 15'h0021, 2'h1, 32'h0000BBAA);
    chk("gain0", 32'(gain[15:0]), 32'h0000AABB);
    xfer(1'b0, 15'h0000, 2'h0, 32'h3);
    xfer(1'b0, 15'h0010, 2'h1, 32'h00005566);
    chk("frozen", 32'(ofs[15:0]), 32'h00000055);
    xfer(1'b0, 15'h0000, 2'h0, 32'h0);
    $display("test direction done");
  endtask
  task automatic t_cal;
    @(posedge clk);
    ocal_en   <= 1'b1;
    ocal_core <= 3'h5;
    ocal_val  <= 16'h1234;
    ocal_we   <= 1'b1;
    @(posedge clk);
    ocal_we   <= 1'b0;
    ocal_en   <= 1'b0;
    repeat (3) @(posedge clk);
    chk("ofs5", 32'(ofs[95:80]), 32'h00001234);
    chk("gain kept", 32'(gain[15:0]), 32'h0000AABB);
    $display("test cal done");
  endtask
  task automatic t_var;
    xfer(1'b0, 15'h0026, 2'h0, 32'h77);
    chk("gain3 quad", 32'(gain[63:48]), 32'h00000077);
    xfer(1'b0, 15'h0007, 2'h0, 32'h5A);
    chk("term c quad", 32'(term[23:16]), 32'h0000005A);
    variant <= VAR_DUAL;
    repeat (3) @(posedge clk);
    chk("gain3 dual", 32'(gain[63:48]), 32'h0);
    chk("term c dual", 32'(term[23:16]), 32'h0);
    xfer(1'b1, 15'h0026, 2'h0, 32'h0);
    chk("gain3 read", 32'(rd[7:0]), 32'h00000077);
    $display("test variant done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_stream();
    t_dir();
    t_cal();
    t_var();
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
